// ===== rtl/vtf_filter.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module vtf_filter #(
	parameter int VID_W = vtf_pkg::VID_W
) (
	input  wire logic        CLOCK_I,
	input  wire logic        RSTN_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        FRAME_VALID_I,
	input  wire logic [7:0]  FRAME_DATA_I,
	input  wire logic        FRAME_LAST_I,
	output logic             FRAME_READY_O,
	output logic             VERDICT_VALID_O,
	output logic             VERDICT_PASS_O,
	output logic             VERDICT_HAS_S_O,
	output logic             VERDICT_HAS_C_O,
	input  wire logic        VERDICT_READY_I
);
	vtf_stream_if #(.W(vtf_pkg::VERDICT_W)) push_if ();
	vtf_stream_if #(.W(vtf_pkg::VERDICT_W)) pop_if ();

	vtf_pkg::vtf_state_t             state_reg;
	logic [4:0]                      cnt_reg;
	logic [7:0]                      hdr_reg [vtf_pkg::HDR_BYTES];
	logic [7:0]                      hdr_cur [vtf_pkg::HDR_BYTES];
	logic [vtf_pkg::CTRL_W-1:0]      ctrl_reg;
	logic [VID_W-1:0]                svid_reg;
	logic [VID_W-1:0]                cvid_reg;
	logic [vtf_pkg::PCP_W-1:0]       spcp_reg;
	logic [vtf_pkg::PCP_W-1:0]       cpcp_reg;
	logic                            sdei_reg;
	logic [vtf_pkg::CNT_W-1:0]       pass_cnt_reg;
	logic [vtf_pkg::CNT_W-1:0]       block_cnt_reg;
	logic [vtf_pkg::VERDICT_W-1:0]   last_reg;
	logic [31:0]                     prdata_reg;
	logic                            pslverr_reg;
	logic                            acc;
	logic                            eof;
	logic [4:0]                      len_cur;
	logic [15:0]                     et1;
	logic [15:0]                     et2;
	logic [vtf_pkg::TCI_W-1:0]       s_tci;
	logic [vtf_pkg::TCI_W-1:0]       c_tci;
	logic                            has_s;
	logic                            has_c;
	logic                            inner_c;
	logic [4:0]                      en;
	logic [4:0]                      ok;
	logic                            dec_pass;
	logic                            setup;
	logic                            wr;
	logic                            hit;
	logic [31:0]                     rd_mux;

	// Stall the source whenever no verdict slot is free
	assign FRAME_READY_O = push_if.ready;
	assign acc           = FRAME_VALID_I & FRAME_READY_O;
	assign eof           = acc & FRAME_LAST_I;

	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			state_reg <= vtf_pkg::ST_HEAD;
			cnt_reg   <= '0;
		end else if (eof) begin
			state_reg <= vtf_pkg::ST_HEAD;
			cnt_reg   <= '0;
		end else if (acc) begin
			case (state_reg)
				vtf_pkg::ST_HEAD: begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == vtf_pkg::LEN_TWO_TAG - 5'h01) begin
						state_reg <= vtf_pkg::ST_TAIL;
					end
				end
				vtf_pkg::ST_TAIL: begin
					cnt_reg <= vtf_pkg::LEN_TWO_TAG;
				end
				default: begin
					state_reg <= vtf_pkg::ST_HEAD;
				end
			endcase
		end
	end

	// Bytes 12 to 19: outer type, outer tag, inner type, inner tag
	for (genvar i = 0; i < vtf_pkg::HDR_BYTES; i++) begin : g_hdr
		always_ff @(posedge CLOCK_I) begin
			if (!RSTN_I) begin
				hdr_reg[i] <= 8'h00;
			end else if (acc && cnt_reg == vtf_pkg::HDR_FIRST + 5'(i)) begin
				hdr_reg[i] <= FRAME_DATA_I;
			end
		end
		assign hdr_cur[i] = (acc && cnt_reg == vtf_pkg::HDR_FIRST + 5'(i)) ?
			FRAME_DATA_I : hdr_reg[i];
	end

	// Stale header bytes are harmless: every use is gated by length
	assign len_cur = (state_reg == vtf_pkg::ST_TAIL) ? vtf_pkg::LEN_TWO_TAG : cnt_reg + 5'h01;
	assign et1     = {hdr_cur[0], hdr_cur[1]};
	assign et2     = {hdr_cur[4], hdr_cur[5]};
	assign has_s   = (len_cur >= vtf_pkg::LEN_ONE_TAG) && (et1 == vtf_pkg::TPID_STAG);
	assign inner_c = has_s && (len_cur >= vtf_pkg::LEN_TWO_TAG) && (et2 == vtf_pkg::TPID_CTAG);
	// A lone TPID_CTAG tag is the customer tag, a lone TPID_STAG tag the service tag
	assign has_c   = inner_c ||
		((len_cur >= vtf_pkg::LEN_ONE_TAG) && (et1 == vtf_pkg::TPID_CTAG));
	assign s_tci   = {hdr_cur[2], hdr_cur[3]};
	assign c_tci   = inner_c ? {hdr_cur[6], hdr_cur[7]} : {hdr_cur[2], hdr_cur[3]};

	assign en = ctrl_reg;
	// Missing tag fails its comparison
	always_comb begin
		ok = '0;
		ok[vtf_pkg::CTRL_SVID] = has_s && (s_tci[vtf_pkg::VID_FIELD_W-1:0] ==
			vtf_pkg::VID_FIELD_W'(svid_reg));
		ok[vtf_pkg::CTRL_SPCP] = has_s &&
			(s_tci[vtf_pkg::TCI_PCP_LSB +: vtf_pkg::PCP_W] == spcp_reg);
		ok[vtf_pkg::CTRL_SDEI] = has_s && (s_tci[vtf_pkg::TCI_DEI_BIT] == sdei_reg);
		ok[vtf_pkg::CTRL_CVID] = has_c && (c_tci[vtf_pkg::VID_FIELD_W-1:0] ==
			vtf_pkg::VID_FIELD_W'(cvid_reg));
		ok[vtf_pkg::CTRL_CPCP] = has_c &&
			(c_tci[vtf_pkg::TCI_PCP_LSB +: vtf_pkg::PCP_W] == cpcp_reg);
	end

	// Ignored settings select nothing on their own
	assign dec_pass = (|en) && (&(~en | ok));

	assign push_if.valid = eof;
	assign push_if.data  = {has_c, has_s, dec_pass};

	vtf_buf2 #(
		.W     (vtf_pkg::VERDICT_W),
		.DEPTH (2)
	) u_buf (
		.clk_i  (CLOCK_I),
		.rstn_i (RSTN_I),
		.in_s   (push_if),
		.out_s  (pop_if)
	);

	assign VERDICT_VALID_O = pop_if.valid;
	assign VERDICT_PASS_O  = pop_if.data[vtf_pkg::VD_PASS];
	assign VERDICT_HAS_S_O = pop_if.data[vtf_pkg::VD_HAS_S];
	assign VERDICT_HAS_C_O = pop_if.data[vtf_pkg::VD_HAS_C];
	assign pop_if.ready    = VERDICT_READY_I;

	// Bus: data latched in setup, so access completes with no wait
	assign setup = PSEL_I & ~PENABLE_I;
	assign wr    = PSEL_I & PENABLE_I & PWRITE_I & ~pslverr_reg;
	assign hit   = (PADDR_I == vtf_pkg::OFS_CTRL) || (PADDR_I == vtf_pkg::OFS_SVAL) ||
		(PADDR_I == vtf_pkg::OFS_CVAL) || (PADDR_I == vtf_pkg::OFS_STAT) ||
		(PADDR_I == vtf_pkg::OFS_PASS) || (PADDR_I == vtf_pkg::OFS_BLOCK);
	assign PREADY_O  = PSEL_I & PENABLE_I;
	assign PRDATA_O  = prdata_reg;
	assign PSLVERR_O = pslverr_reg & PSEL_I & PENABLE_I;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (PADDR_I)
			vtf_pkg::OFS_CTRL: begin
				rd_mux[vtf_pkg::CTRL_W-1:0] = ctrl_reg;
			end
			vtf_pkg::OFS_SVAL: begin
				rd_mux[vtf_pkg::VAL_VID_LSB +: VID_W]         = svid_reg;
				rd_mux[vtf_pkg::VAL_PCP_LSB +: vtf_pkg::PCP_W] = spcp_reg;
				rd_mux[vtf_pkg::VAL_DEI_BIT]                   = sdei_reg;
			end
			vtf_pkg::OFS_CVAL: begin
				rd_mux[vtf_pkg::VAL_VID_LSB +: VID_W]         = cvid_reg;
				rd_mux[vtf_pkg::VAL_PCP_LSB +: vtf_pkg::PCP_W] = cpcp_reg;
			end
			vtf_pkg::OFS_STAT: begin
				rd_mux[vtf_pkg::VERDICT_W-1:0] = last_reg;
			end
			vtf_pkg::OFS_PASS: begin
				rd_mux = pass_cnt_reg;
			end
			vtf_pkg::OFS_BLOCK: begin
				rd_mux = block_cnt_reg;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			prdata_reg  <= vtf_pkg::REG_RST;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg  <= PWRITE_I ? 32'h0000_0000 : rd_mux;
			pslverr_reg <= ~hit;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			ctrl_reg <= vtf_pkg::CTRL_W'(vtf_pkg::REG_RST);
			svid_reg <= '0;
			spcp_reg <= '0;
			sdei_reg <= 1'b0;
			cvid_reg <= '0;
			cpcp_reg <= '0;
		end else if (wr) begin
			if (PADDR_I == vtf_pkg::OFS_CTRL) begin
				ctrl_reg <= PWDATA_I[vtf_pkg::CTRL_W-1:0];
			end
			if (PADDR_I == vtf_pkg::OFS_SVAL) begin
				svid_reg <= PWDATA_I[vtf_pkg::VAL_VID_LSB +: VID_W];
				spcp_reg <= PWDATA_I[vtf_pkg::VAL_PCP_LSB +: vtf_pkg::PCP_W];
				sdei_reg <= PWDATA_I[vtf_pkg::VAL_DEI_BIT];
			end
			if (PADDR_I == vtf_pkg::OFS_CVAL) begin
				cvid_reg <= PWDATA_I[vtf_pkg::VAL_VID_LSB +: VID_W];
				cpcp_reg <= PWDATA_I[vtf_pkg::VAL_PCP_LSB +: vtf_pkg::PCP_W];
			end
		end
	end

	// Counting beats clearing: a frame ending in the clear cycle counts as one
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			pass_cnt_reg  <= '0;
			block_cnt_reg <= '0;
			last_reg      <= '0;
		end else begin
			if (eof) begin
				last_reg <= push_if.data;
			end
			if (wr && PADDR_I == vtf_pkg::OFS_PASS) begin
				pass_cnt_reg <= (eof && dec_pass) ? 32'h0000_0001 : 32'h0000_0000;
			end else if (eof && dec_pass) begin
				pass_cnt_reg <= pass_cnt_reg + 32'h0000_0001;
			end
			if (wr && PADDR_I == vtf_pkg::OFS_BLOCK) begin
				block_cnt_reg <= (eof && !dec_pass) ? 32'h0000_0001 : 32'h0000_0000;
			end else if (eof && !dec_pass) begin
				block_cnt_reg <= block_cnt_reg + 32'h0000_0001;
			end
		end
	end

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);

	property p_single_is_customer;
		eof && len_cur >= vtf_pkg::LEN_ONE_TAG && et1 == vtf_pkg::TPID_CTAG |-> has_c && !has_s;
	endproperty
	a_single_is_customer: assert property (p_single_is_customer) else $error("single tag misread");

	property p_double;
		eof && len_cur == vtf_pkg::LEN_TWO_TAG && et1 == vtf_pkg::TPID_STAG &&
			et2 == vtf_pkg::TPID_CTAG |-> has_s && has_c;
	endproperty
	a_double: assert property (p_double) else $error("double tag misread");

	property p_all_ignore;
		eof && en == '0 |=> last_reg[vtf_pkg::VD_PASS] == 1'b0;
	endproperty
	a_all_ignore: assert property (p_all_ignore) else $error("ignore selected a frame");

	property p_svid_mismatch;
		eof && en[vtf_pkg::CTRL_SVID] && has_s &&
			s_tci[vtf_pkg::VID_FIELD_W-1:0] != vtf_pkg::VID_FIELD_W'(svid_reg) |-> !dec_pass;
	endproperty
	a_svid_mismatch: assert property (p_svid_mismatch) else $error("vid mismatch passed");

	property p_cpcp_mismatch;
		eof && en[vtf_pkg::CTRL_CPCP] && has_c &&
			c_tci[vtf_pkg::TCI_PCP_LSB +: vtf_pkg::PCP_W] != cpcp_reg |-> !dec_pass;
	endproperty
	a_cpcp_mismatch: assert property (p_cpcp_mismatch) else $error("pcp mismatch passed");

	property p_dei_mismatch;
		eof && en[vtf_pkg::CTRL_SDEI] && has_s &&
			s_tci[vtf_pkg::TCI_DEI_BIT] != sdei_reg |-> !dec_pass;
	endproperty
	a_dei_mismatch: assert property (p_dei_mismatch) else $error("dei mismatch passed");

	property p_missing_tag;
		eof && en[vtf_pkg::CTRL_SVID] && !has_s |=> !last_reg[vtf_pkg::VD_PASS];
	endproperty
	a_missing_tag: assert property (p_missing_tag) else $error("untagged frame passed");

	property p_pass_count;
		eof && dec_pass && !(wr && PADDR_I == vtf_pkg::OFS_PASS) |=>
			pass_cnt_reg == $past(pass_cnt_reg) + 32'h0000_0001;
	endproperty
	a_pass_count: assert property (p_pass_count) else $error("pass count missed");

	property p_verdict_out;
		eof ##1 (!VERDICT_VALID_O) [*1] |-> 1'b0;
	endproperty
	a_verdict_out: assert property (p_verdict_out) else $error("verdict not queued");

	c_pass:    cover property (eof && dec_pass && has_s && has_c);
	c_block:   cover property (eof && !dec_pass && |en);
	c_full:    cover property (!push_if.ready ##1 push_if.ready);
	c_single:  cover property (eof && has_c && !has_s && dec_pass);
endmodule

// ===== pkg/vtf_pkg.sv
package vtf_pkg;
	localparam int          VID_W        = 10;
	localparam int          PCP_W        = 3;
	localparam int          TCI_W        = 16;
	localparam int          VID_FIELD_W  = 12;
	localparam int          HDR_BYTES    = 8;
	localparam int          VERDICT_W    = 3;
	localparam int          CNT_W        = 32;

	localparam logic [15:0] TPID_STAG    = 16'h88a8;
	localparam logic [15:0] TPID_CTAG    = 16'h8100;

	// Byte positions within a frame
	localparam logic [4:0]  HDR_FIRST    = 5'h0c;
	localparam logic [4:0]  LEN_ONE_TAG  = 5'h10;
	localparam logic [4:0]  LEN_TWO_TAG  = 5'h14;

	// Tag control field layout
	localparam int          TCI_PCP_LSB  = 13;
	localparam int          TCI_DEI_BIT  = 12;

	// Register byte offsets
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_SVAL     = 12'h004;
	localparam logic [11:0] OFS_CVAL     = 12'h008;
	localparam logic [11:0] OFS_STAT     = 12'h00c;
	localparam logic [11:0] OFS_PASS     = 12'h010;
	localparam logic [11:0] OFS_BLOCK    = 12'h014;

	// Control field positions
	localparam int          CTRL_SVID    = 0;
	localparam int          CTRL_SPCP    = 1;
	localparam int          CTRL_SDEI    = 2;
	localparam int          CTRL_CVID    = 3;
	localparam int          CTRL_CPCP    = 4;
	localparam int          CTRL_W       = 5;

	// Value register field positions
	localparam int          VAL_VID_LSB  = 0;
	localparam int          VAL_PCP_LSB  = 12;
	localparam int          VAL_DEI_BIT  = 16;

	// Verdict word bits
	localparam int          VD_PASS      = 0;
	localparam int          VD_HAS_S     = 1;
	localparam int          VD_HAS_C     = 2;

	localparam logic [31:0] REG_RST      = 32'h0000_0000;

	typedef enum logic {
		MATCH_IGNORE = 1'b0,
		MATCH_EQUAL  = 1'b1
	} vtf_match_t;

	typedef enum logic [1:0] {
		ST_HEAD = 2'b01,
		ST_TAIL = 2'b10
	} vtf_state_t;
endpackage

// ===== pkg/vtf_stream_if.sv
`timescale 1ns/1ps
interface vtf_stream_if #(
	parameter int W = 3
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/vtf_buf2.sv
`timescale 1ns/1ps
module vtf_buf2 #(
	parameter int W     = 3,
	parameter int DEPTH = 2
) (
	input  wire logic  clk_i,
	input  wire logic  rstn_i,
	vtf_stream_if.snk  in_s,
	vtf_stream_if.src  out_s
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0]  mem_reg [DEPTH];
	logic [PW-1:0] wr_reg;
	logic [PW-1:0] rd_reg;
	logic [PW:0]   count_reg;
	logic          push;
	logic          pop;

	// Full and empty come straight from the fill count
	assign in_s.ready  = (count_reg != (PW+1)'(DEPTH));
	assign out_s.valid = (count_reg != '0);
	assign out_s.data  = mem_reg[rd_reg];
	assign push        = in_s.valid & in_s.ready;
	assign pop         = out_s.valid & out_s.ready;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_reg] <= in_s.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
			end
			if (pop) begin
				rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			count_reg <= '0;
		end else if (push && !pop) begin
			count_reg <= count_reg + (PW+1)'(1);
		end else if (pop && !push) begin
			count_reg <= count_reg - (PW+1)'(1);
		end
	end
endmodule

// ===== tb/vtf_frame_src.sv
`timescale 1ns/1ps
module vtf_frame_src (
	input  wire logic       clk_i,
	input  wire logic       ready_i,
	output logic            valid_o,
	output logic      [7:0] data_o,
	output logic            last_o
);
	initial begin
		valid_o = 1'b0;
		data_o  = 8'h00;
		last_o  = 1'b0;
	end

	// Bytes leave in wire order, each held until taken
	// Idle data is inverted so a stale byte never looks valid
	task automatic send(input logic [7:0] bytes[$], input logic slow);
		@(posedge clk_i);
		foreach (bytes[i]) begin
			if (slow && (i % 3 == 1)) begin
				valid_o <= 1'b0;
				data_o  <= ~data_o;
				last_o  <= 1'b0;
				@(posedge clk_i);
			end
			valid_o <= 1'b1;
			data_o  <= bytes[i];
			last_o  <= (i == bytes.size() - 1);
			// Ready is taken at the same edge the block samples the byte
			do begin
				@(posedge clk_i);
			end while (ready_i !== 1'b1);
		end
		valid_o <= 1'b0;
		data_o  <= ~data_o;
		last_o  <= 1'b0;
	endtask
endmodule

// ===== tb/tb_vtf_filter.sv
`timescale 1ns/1ps
module tb_vtf_filter;
	logic        CLOCK_I = 1'b0;
	logic        RSTN_I = 1'b0;
	logic        PSEL_I = 1'b0;
	logic        PENABLE_I = 1'b0;
	logic        PWRITE_I = 1'b0;
	logic [11:0] PADDR_I = 12'h000;
	logic [31:0] PWDATA_I = 32'h0000_0000;
	logic [31:0] PRDATA_O;
	logic        PREADY_O;
	logic        PSLVERR_O;
	logic        FRAME_VALID_I;
	logic [7:0]  FRAME_DATA_I;
	logic        FRAME_LAST_I;
	logic        FRAME_READY_O;
	logic        VERDICT_VALID_O;
	logic        VERDICT_PASS_O;
	logic        VERDICT_HAS_S_O;
	logic        VERDICT_HAS_C_O;
	logic        VERDICT_READY_I = 1'b0;
	int          seed = 94087;
	int          miscompares = 0;
	int          total_checks = 0;
	logic        hold = 1'b1;
	logic        saw_full = 1'b0;
	logic [2:0]  exp_q[$];

	always #10 CLOCK_I = ~CLOCK_I;

	vtf_filter vtf_filter_inst (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
		.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
		.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
		.FRAME_VALID_I(FRAME_VALID_I), .FRAME_DATA_I(FRAME_DATA_I),
		.FRAME_LAST_I(FRAME_LAST_I), .FRAME_READY_O(FRAME_READY_O),
		.VERDICT_VALID_O(VERDICT_VALID_O), .VERDICT_PASS_O(VERDICT_PASS_O),
		.VERDICT_HAS_S_O(VERDICT_HAS_S_O), .VERDICT_HAS_C_O(VERDICT_HAS_C_O),
		.VERDICT_READY_I(VERDICT_READY_I));

	vtf_frame_src vtf_frame_src_inst (.clk_i(CLOCK_I), .ready_i(FRAME_READY_O),
		.valid_o(FRAME_VALID_I), .data_o(FRAME_DATA_I), .last_o(FRAME_LAST_I));

	task automatic stop_test();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge CLOCK_I);
		PSEL_I    <= 1'b1;
		PENABLE_I <= 1'b0;
		PWRITE_I  <= w;
		PADDR_I   <= a;
		PWDATA_I  <= d;
		@(posedge CLOCK_I);
		PENABLE_I <= 1'b1;
		n = 0;
		// Answer taken at the rising edge that sees ready high, then released
		do begin
			@(posedge CLOCK_I);
			n++;
		end while (PREADY_O !== 1'b1 && n < 20);
		if (n >= 20) check("pready", {31'h0, PREADY_O}, 32'h1);
		rd = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I    <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask

	// Expected {has_c, has_s, pass}; all-ignore selects nothing
	function automatic logic [2:0] exp_v(logic [4:0] ctrl, logic [31:0] sv, logic [31:0] cv,
		int kind, logic [15:0] st, logic [15:0] ct);
		logic hs;
		logic hc;
		logic ok;
		hs = (kind >= 2);
		hc = (kind == 1 || kind == 2);
		ok = (ctrl != 5'h00);
		if (ctrl[0]) ok &= hs && (st[11:0] == {2'b00, sv[9:0]});
		if (ctrl[1]) ok &= hs && (st[15:13] == sv[14:12]);
		if (ctrl[2]) ok &= hs && (st[12] == sv[16]);
		if (ctrl[3]) ok &= hc && (ct[11:0] == {2'b00, cv[9:0]});
		if (ctrl[4]) ok &= hc && (ct[15:13] == cv[14:12]);
		return {hc, hs, ok};
	endfunction

	// Random tag biased toward the configured value, sometimes with upper VID bits set
	task automatic mk_tci(input logic [31:0] v, output logic [15:0] t);
		logic [3:0] m;
		t = 16'($random(seed));
		m = 4'($random(seed));
		if (m[0]) t[11:0] = {2'b00, v[9:0]};
		if (m[0] && m[1] && m[2] && m[3]) t[11:10] = 2'b01;
		if (m[2]) t[15:13] = v[14:12];
		if (m[3]) t[12] = v[16];
	endtask

	always @(posedge CLOCK_I) VERDICT_READY_I <= ~hold & 1'($random(seed));

	always @(negedge CLOCK_I) begin
		if (RSTN_I) begin
			if (FRAME_READY_O === 1'b0) saw_full = 1'b1;
			if (VERDICT_VALID_O === 1'b1 && VERDICT_READY_I) begin
				if (exp_q.size() == 0) begin
					check("spurious_verdict", 32'h1, 32'h0);
				end else begin
					check("verdict", {29'h0, VERDICT_HAS_C_O, VERDICT_HAS_S_O, VERDICT_PASS_O},
						{29'h0, exp_q.pop_front()});
				end
			end
		end
	end

	initial begin
		repeat (50000) @(posedge CLOCK_I);
		miscompares++;
		stop_test();
	end

	initial begin
		logic [31:0] rd;
		logic        er;
		logic [4:0]  ctrl;
		logic [31:0] sv;
		logic [31:0] cv;
		logic [15:0] st;
		logic [15:0] ct;
		logic [7:0]  q[$];
		logic [2:0]  e;
		int          kind;
		int          np;
		int          n;
		repeat (6) @(posedge CLOCK_I);
		RSTN_I <= 1'b1;
		apb(1'b0, vtf_pkg::OFS_CTRL, 32'h0, rd, er);
		check("ctrl_reset", rd, vtf_pkg::REG_RST);
		apb(1'b0, 12'h018, 32'h0, rd, er);
		check("unmapped_err", {31'h0, er}, 32'h1);
		check("unmapped_data", rd, 32'h0);
		// Consumer stalls first so both verdict slots fill and input is refused
		// Long enough for two whole frames even with gaps
		fork
			begin
				repeat (200) @(posedge CLOCK_I);
				hold <= 1'b0;
			end
		join_none
		for (int c = 0; c < 14; c++) begin
			ctrl = (c < 5) ? (5'h01 << c) : (c == 5) ? 5'h00 : (c == 6) ? 5'h1f :
				5'($random(seed));
			sv = $random(seed) & 32'h0001_73ff;
			cv = $random(seed) & 32'h0000_73ff;
			apb(1'b1, vtf_pkg::OFS_CTRL, {27'h0, ctrl}, rd, er);
			apb(1'b1, vtf_pkg::OFS_SVAL, sv, rd, er);
			apb(1'b1, vtf_pkg::OFS_CVAL, cv, rd, er);
			apb(1'b1, vtf_pkg::OFS_PASS, 32'hffff_ffff, rd, er);
			apb(1'b1, vtf_pkg::OFS_BLOCK, 32'h0, rd, er);
			apb(1'b0, vtf_pkg::OFS_SVAL, 32'h0, rd, er);
			check("sval", rd, sv);
			apb(1'b0, vtf_pkg::OFS_CVAL, 32'h0, rd, er);
			check("cval", rd, cv);
			apb(1'b0, vtf_pkg::OFS_CTRL, 32'h0, rd, er);
			check("ctrl", rd, {27'h0, ctrl});
			np = 0;
			for (int f = 0; f < 8; f++) begin
				kind = (f < 4) ? f : ($random(seed) & 3);
				mk_tci(sv, st);
				mk_tci(cv, ct);
				q = {};
				repeat (12) q.push_back(8'($random(seed)));
				if (kind >= 2) q = {q, vtf_pkg::TPID_STAG[15:8], vtf_pkg::TPID_STAG[7:0],
					st[15:8], st[7:0]};
				if (kind == 1 || kind == 2) q = {q, vtf_pkg::TPID_CTAG[15:8],
					vtf_pkg::TPID_CTAG[7:0], ct[15:8], ct[7:0]};
				q = {q, 8'h08, 8'h00};
				repeat (4) q.push_back(8'($random(seed)));
				e = exp_v(ctrl, sv, cv, kind, st, ct);
				np += e[0];
				exp_q.push_back(e);
				vtf_frame_src_inst.send(q, 1'($random(seed)));
			end
			n = 0;
			while (exp_q.size() != 0 && n < 500) begin
				@(posedge CLOCK_I);
				n++;
			end
			if (n >= 500) check("drain", 32'h1, 32'h0);
			apb(1'b0, vtf_pkg::OFS_PASS, 32'h0, rd, er);
			check("pass_count", rd, np);
			apb(1'b0, vtf_pkg::OFS_BLOCK, 32'h0, rd, er);
			check("block_count", rd, 8 - np);
			apb(1'b0, vtf_pkg::OFS_STAT, 32'h0, rd, er);
			check("stat", rd, {29'h0, e});
		end
		check("input_refused", {31'h0, saw_full}, 32'h1);
		stop_test();
	end
endmodule
